// ---- rtl/pfp_device.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pfp_map.svh"

module pfp_device
    import pfp_pkg::*;
#(
    parameter int FLASH_WORDS = 8192,
    parameter int PAGE_WORDS  = 64,
    parameter int EE_BYTES    = 512,
    parameter int PROG_CYCLES = `PFP_PROG_CYCLES
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // programming pins
    pfp_link_if.dev             link,
    // fuse and lock bits
    input  wire logic           eeprom_preserve_fuse,
    input  wire logic           lock_write,
    input  wire logic [3:0]     lock_value,
    output logic      [3:0]     boot_lock,
    // observation
    input  wire logic [15:0]    rd_addr,
    output logic      [15:0]    rd_data,
    output logic      [7:0]     ee_rd_data,
    output logic      [7:0]     command,
    output logic                busy
);

    localparam int FA = $clog2(FLASH_WORDS);
    localparam int PA = $clog2(PAGE_WORDS);
    localparam int EA = $clog2(EE_BYTES);
    localparam logic [15:0] ERASE_LAST = 16'(FLASH_WORDS - 1);
    localparam logic [15:0] PROG_LAST  =
        16'((PROG_CYCLES > PAGE_WORDS ? PROG_CYCLES : PAGE_WORDS) - 1);
    localparam logic [15:0] EE_TOP     = 16'(EE_BYTES);

    pfp_dev_state_e state;
    logic [15:0]    cnt;
    logic           load_q;
    logic           page_latch_strobe_q;
    logic           wr_q;
    logic [7:0]     addr_lo;
    logic [7:0]     addr_hi;
    logic [7:0]     data_lo;
    logic [7:0]     data_hi;
    logic [15:0]    flash [FLASH_WORDS];
    logic [15:0]    page_buf [PAGE_WORDS];
    logic [7:0]     eeprom [EE_BYTES];

    // ------------------------------------------------------------
    // strobe edges
    // ------------------------------------------------------------
    logic       load_rise;
    logic       page_latch_strobe_rise;
    logic       wr_fall;
    logic       start;
    logic       idle;
    logic [1:0] act;
    logic [15:0] word_addr;
    logic [15:0] prog_addr;

    assign idle       = (state == DS_IDLE);
    assign load_rise  = link.load_strobe & ~load_q & idle;
    assign page_latch_strobe_rise = link.page_latch_strobe & ~page_latch_strobe_q & idle;
    assign wr_fall    = ~link.write_strobe_n & wr_q & idle;
    assign start      = wr_fall && (command == `PFP_CMD_CHIP_ERASE
                        || command == `PFP_CMD_WRITE_FLASH);
    assign act        = {link.action_select_high, link.action_select_low};
    assign word_addr  = {addr_hi, addr_lo};
    assign prog_addr  = {word_addr[15:PA], cnt[PA-1:0]};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_q  <= 1'b0;
            page_latch_strobe_q <= 1'b0;
            wr_q    <= 1'b1;
        end else begin
            load_q  <= link.load_strobe;
            page_latch_strobe_q <= link.page_latch_strobe;
            wr_q    <= link.write_strobe_n;
        end
    end

    // ------------------------------------------------------------
    // command, address and data loads
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            command <= `PFP_CMD_RESET;
        end else if (load_rise && act == `PFP_ACT_CMD) begin
            command <= link.data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
        end else if (load_rise && act == `PFP_ACT_ADDR) begin
            if (!link.byte_select_one) begin
                addr_lo <= link.data;
            end else begin
                addr_hi <= link.data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_lo <= 8'h00;
            data_hi <= 8'h00;
        end else if (load_rise && act == `PFP_ACT_DATA) begin
            if (link.byte_select_one) begin
                data_hi <= link.data;
            end else begin
                data_lo <= link.data;
            end
        end
    end

    // ------------------------------------------------------------
    // page buffer fill
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (page_latch_strobe_rise && link.byte_select_one
            && command == `PFP_CMD_WRITE_FLASH) begin
            page_buf[addr_lo[PA-1:0]] <= {data_hi, data_lo};
        end
    end

    // ------------------------------------------------------------
    // erase and program sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= DS_IDLE;
            cnt   <= 16'h0000;
        end else begin
            unique case (state)
                DS_IDLE: begin
                    cnt <= 16'h0000;
                    if (wr_fall && command == `PFP_CMD_CHIP_ERASE) begin
                        state <= DS_ERASE;
                    end else if (wr_fall
                                 && command == `PFP_CMD_WRITE_FLASH) begin
                        state <= DS_PROG;
                    end
                end
                DS_ERASE: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == ERASE_LAST) begin
                        state <= DS_IDLE;
                    end
                end
                DS_PROG: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == PROG_LAST) begin
                        state <= DS_IDLE;
                    end
                end
            endcase
        end
    end

    // ready/busy pin and status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.ready_busy_out <= 1'b1;
            busy                <= 1'b0;
        end else begin
            link.ready_busy_out <= idle && !start;
            busy                <= !(idle && !start);
        end
    end

    // ------------------------------------------------------------
    // memory arrays
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (state == DS_ERASE) begin
            flash[cnt[FA-1:0]] <= `PFP_FLASH_BLANK;
        end else if (state == DS_PROG && cnt < 16'(PAGE_WORDS)) begin
            flash[prog_addr[FA-1:0]] <= page_buf[cnt[PA-1:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (state == DS_ERASE && cnt < EE_TOP
            && !eeprom_preserve_fuse) begin
            eeprom[cnt[EA-1:0]] <= `PFP_EE_BLANK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data    <= 16'h0000;
            ee_rd_data <= 8'h00;
        end else begin
            rd_data    <= flash[rd_addr[FA-1:0]];
            ee_rd_data <= eeprom[rd_addr[EA-1:0]];
        end
    end

    // ------------------------------------------------------------
    // boot lock bits
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_lock <= `PFP_LOCK_CLEAR;
        end else if (state == DS_ERASE && cnt == ERASE_LAST) begin
            boot_lock <= `PFP_LOCK_CLEAR;
        end else if (lock_write) begin
            boot_lock <= boot_lock & lock_value;
        end
    end

endmodule // pfp_device

`default_nettype wire

// ---- rtl/pfp_map.svh ----
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH

// ----------------------------------------------------------------
// action-select patterns {high, low}
// ----------------------------------------------------------------
`define PFP_ACT_ADDR        2'h0
`define PFP_ACT_DATA        2'h1
`define PFP_ACT_CMD         2'h2

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define PFP_CMD_CHIP_ERASE  8'h80
`define PFP_CMD_WRITE_FLASH 8'h10

// ----------------------------------------------------------------
// reset and erased values
// ----------------------------------------------------------------
`define PFP_CMD_RESET       8'h00
`define PFP_LOCK_CLEAR      4'hF
`define PFP_FLASH_BLANK     16'hFFFF
`define PFP_EE_BLANK        8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PFP_CLK_PERIOD_NS   100
`define PFP_PROG_TIME_NS    4000
`define PFP_PROG_CYCLES \
    ((`PFP_PROG_TIME_NS + `PFP_CLK_PERIOD_NS - 1) / `PFP_CLK_PERIOD_NS)

`endif

// ---- rtl/pfp_pkg.sv ----
package pfp_pkg;

    // ------------------------------------------------------------
    // device states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DS_IDLE  = 3'h1,
        DS_ERASE = 3'h2,
        DS_PROG  = 3'h4
    } pfp_dev_state_e;

    // ------------------------------------------------------------
    // programmer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        PS_IDLE  = 5'h01,
        PS_SETUP = 5'h02,
        PS_PULSE = 5'h04,
        PS_HOLD  = 5'h08,
        PS_WAIT  = 5'h10
    } pfp_prog_state_e;

    // ------------------------------------------------------------
    // programmer request kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RK_CMD     = 3'h0,
        RK_ADDR_LO = 3'h1,
        RK_ADDR_HI = 3'h2,
        RK_DATA_LO = 3'h3,
        RK_DATA_HI = 3'h4,
        RK_PAGE_LATCH_STROBE   = 3'h5,
        RK_WRITE   = 3'h6
    } pfp_req_e;

endpackage

// ---- rtl/pfp_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface pfp_link_if;
    logic [7:0] data;
    logic       action_select_high;
    logic       action_select_low;
    logic       byte_select_one;
    logic       load_strobe;
    logic       page_latch_strobe;
    logic       write_strobe_n;
    logic       ready_busy_out;

    modport dev (
        input  data,
        input  action_select_high,
        input  action_select_low,
        input  byte_select_one,
        input  load_strobe,
        input  page_latch_strobe,
        input  write_strobe_n,
        output ready_busy_out
    );

    modport prog (
        output data,
        output action_select_high,
        output action_select_low,
        output byte_select_one,
        output load_strobe,
        output page_latch_strobe,
        output write_strobe_n,
        input  ready_busy_out
    );
endinterface

`default_nettype wire

// ---- rtl/pfp_programmer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pfp_map.svh"

module pfp_programmer
    import pfp_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // programming pins
    pfp_link_if.prog            link,
    // request side
    input  wire logic           req_valid,
    input  wire pfp_req_e       req_kind,
    input  wire logic [7:0]     req_data,
    output logic                req_ready,
    output logic                dev_ready
);

    pfp_prog_state_e state;
    pfp_req_e        kind;
    logic            take;

    assign take = req_valid && req_ready && link.ready_busy_out;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= PS_IDLE;
            kind      <= RK_CMD;
            req_ready <= 1'b1;
        end else begin
            unique case (state)
                PS_IDLE: begin
                    if (take) begin
                        state     <= PS_SETUP;
                        kind      <= req_kind;
                        req_ready <= 1'b0;
                    end
                end
                PS_SETUP: state <= PS_PULSE;
                PS_PULSE: state <= PS_HOLD;
                PS_HOLD: begin
                    if (kind == RK_WRITE) begin
                        state <= PS_WAIT;
                    end else begin
                        state     <= PS_IDLE;
                        req_ready <= 1'b1;
                    end
                end
                PS_WAIT: begin
                    if (link.ready_busy_out) begin
                        state     <= PS_IDLE;
                        req_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // select pins and data bus
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.data               <= 8'h00;
            link.action_select_high <= 1'b0;
            link.action_select_low  <= 1'b0;
            link.byte_select_one    <= 1'b0;
        end else if (take) begin
            link.data <= req_data;
            unique case (req_kind)
                RK_CMD: begin
                    {link.action_select_high, link.action_select_low}
                        <= `PFP_ACT_CMD;
                    link.byte_select_one <= 1'b0;
                end
                RK_ADDR_LO, RK_ADDR_HI: begin
                    {link.action_select_high, link.action_select_low}
                        <= `PFP_ACT_ADDR;
                    link.byte_select_one <= (req_kind == RK_ADDR_HI);
                end
                RK_DATA_LO, RK_DATA_HI: begin
                    {link.action_select_high, link.action_select_low}
                        <= `PFP_ACT_DATA;
                    link.byte_select_one <= (req_kind == RK_DATA_HI);
                end
                RK_PAGE_LATCH_STROBE: begin
                    link.byte_select_one <= 1'b1;
                end
                default: begin
                    link.byte_select_one <= link.byte_select_one;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.load_strobe       <= 1'b0;
            link.page_latch_strobe <= 1'b0;
            link.write_strobe_n    <= 1'b1;
        end else begin
            link.load_strobe <= (state == PS_SETUP) && kind != RK_PAGE_LATCH_STROBE
                                && kind != RK_WRITE;
            link.page_latch_strobe <= (state == PS_SETUP)
                                      && kind == RK_PAGE_LATCH_STROBE;
            link.write_strobe_n <= !((state == PS_SETUP)
                                     && kind == RK_WRITE);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dev_ready <= 1'b1;
        end else begin
            dev_ready <= link.ready_busy_out;
        end
    end

endmodule // pfp_programmer

`default_nettype wire

// ---- sim/pfp_link_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module pfp_link_sva #(
    parameter int FLASH_WORDS = 256
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // link pins
    input wire logic [7:0] data,
    input wire logic       action_select_high,
    input wire logic       action_select_low,
    input wire logic       byte_select_one,
    input wire logic       load_strobe,
    input wire logic       page_latch_strobe,
    input wire logic       write_strobe_n,
    input wire logic       ready_busy_out
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [7:0] last_cmd;
    logic       hi_seen;
    int         low_cnt;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_cmd <= 8'h00;
        end else if (load_strobe && action_select_high
                     && !action_select_low) begin
            last_cmd <= data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_seen <= 1'b0;
        end else if (load_strobe) begin
            hi_seen <= !action_select_high && action_select_low
                       && byte_select_one;
        end else if (page_latch_strobe) begin
            hi_seen <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt <= 0;
        end else if (ready_busy_out) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_LOAD_PULSE: assert property (load_strobe |=> !load_strobe)
        else $error("load strobe longer than one cycle");
    AST_SEL_STABLE: assert property (load_strobe |-> $stable(data)
        && $stable({action_select_high, action_select_low, byte_select_one}))
        else $error("bus changed with load strobe");
    AST_PATTERN: assert property (load_strobe
        |-> !(action_select_high && action_select_low))
        else $error("unused action pattern loaded");
    AST_CMD_BS0: assert property (load_strobe && action_select_high
        |-> !byte_select_one)
        else $error("command loaded with byte select high");
    AST_PAGE_LATCH_STROBE: assert property (page_latch_strobe
        |-> byte_select_one ##1 !page_latch_strobe)
        else $error("page latch without byte select or too long");
    AST_PAGE_LATCH_STROBE_ORDER: assert property (page_latch_strobe |-> hi_seen)
        else $error("page latch not after high data byte");
    AST_WR_PULSE: assert property ($fell(write_strobe_n)
        |=> write_strobe_n)
        else $error("write strobe longer than one cycle");
    AST_WR_BUSY: assert property (!write_strobe_n
        && $past(write_strobe_n)
        && ready_busy_out && (last_cmd == 8'h80 || last_cmd == 8'h10)
        |=> !ready_busy_out)
        else $error("busy not raised by write strobe");
    AST_NO_LOAD_BUSY: assert property (!ready_busy_out
        |-> !load_strobe && !page_latch_strobe)
        else $error("strobe while busy");
    AST_ERASE_LEN: assert property ($rose(ready_busy_out)
        && last_cmd == 8'h80 |-> low_cnt >= FLASH_WORDS)
        else $error("erase ended too soon");
endmodule // pfp_link_sva

`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import pfp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk, rstn, fuse, lock_wr, req_valid, req_ready, dev_ready;
    logic        busy;
    logic [3:0]  lock_val, boot, lock_m;
    logic [15:0] rd_addr, rd_data, w;
    logic [7:0]  ee, cmd_o, a;
    logic [31:0] seed, r;
    pfp_req_e    req_kind;
    logic [7:0]  req_data;
    logic [15:0] model [256];
    logic [7:0]  q [$];
    int          fail_count, tests_run, cycles, busy_n;

    pfp_link_if link();

    pfp_device #(.FLASH_WORDS(256), .PAGE_WORDS(16), .EE_BYTES(64),
        .PROG_CYCLES(20)) i_pfp_device (.clk(clk), .rstn(rstn),
        .link(link), .eeprom_preserve_fuse(fuse), .lock_write(lock_wr),
        .lock_value(lock_val), .boot_lock(boot), .rd_addr(rd_addr),
        .rd_data(rd_data), .ee_rd_data(ee), .command(cmd_o), .busy(busy));

    pfp_programmer i_pfp_programmer (.clk(clk), .rstn(rstn), .link(link),
        .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data),
        .req_ready(req_ready), .dev_ready(dev_ready));

    pfp_link_sva #(.FLASH_WORDS(256)) i_pfp_link_sva (.clk(clk),
        .rstn(rstn), .data(link.data),
        .action_select_high(link.action_select_high),
        .action_select_low(link.action_select_low),
        .byte_select_one(link.byte_select_one),
        .load_strobe(link.load_strobe),
        .page_latch_strobe(link.page_latch_strobe),
        .write_strobe_n(link.write_strobe_n),
        .ready_busy_out(link.ready_busy_out));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic conclude();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic send(input pfp_req_e k, input logic [7:0] d);
        req_valid <= 1'b1;
        req_kind  <= k;
        req_data  <= d;
        do @(posedge clk);
        while (!(req_ready === 1'b1 && link.ready_busy_out === 1'b1));
        req_valid <= 1'b0;
        busy_n = 0;
        do begin
            @(posedge clk);
            if (busy === 1'b1) busy_n++;
        end while (req_ready !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] ad);
        rd_addr <= {8'h00, ad};
        @(posedge clk);
        @(posedge clk);
    endtask

    task automatic lock(input logic [3:0] v);
        lock_wr  <= 1'b1;
        lock_val <= v;
        @(posedge clk);
        lock_wr <= 1'b0;
        lock_m = lock_m & v;
        @(posedge clk);
        chk("boot_lock", {12'h000, lock_m}, {12'h000, boot});
    endtask

    task automatic erase(input logic f);
        fuse <= f;
        send(RK_CMD, 8'h80);
        chk("command", 16'h0080, {8'h00, cmd_o});
        send(RK_WRITE, 8'h00);
        chk("erase_busy", 16'h0001, {15'h0000, busy_n >= 256});
        chk("dev_ready", 16'h0001, {15'h0000, dev_ready});
        foreach (model[i]) model[i] = 16'hFFFF;
        lock_m = 4'hF;
        chk("boot_lock", 16'h000F, {12'h000, boot});
        for (int i = 0; i < 256; i += 63) begin
            rd(i[7:0]);
            chk("flash", model[i], rd_data);
            chk("eeprom", {15'h0000, !f}, {15'h0000, ee === 8'hFF});
        end
        $display("test erase done");
    endtask

    // ------------------------------------------------------------
    // clock and timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        fuse = 1'b0;
        lock_wr = 1'b0;
        lock_val = 4'h0;
        rd_addr = 16'h0000;
        req_valid = 1'b0;
        req_kind = RK_CMD;
        req_data = 8'h00;
        seed = 32'hA8255827;
        lock_m = 4'hF;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("command", 16'h0000, {8'h00, cmd_o});
        chk("ready", 16'h0001, {15'h0000, link.ready_busy_out});
        chk("dev_ready", 16'h0001, {15'h0000, dev_ready});
        send(RK_WRITE, 8'h00);
        chk("idle_write", 16'h0000, {15'h0000, busy_n > 0});
        $display("test reset done");
        lock(4'hA);
        lock(4'h5);
        $display("test lock done");
        erase(1'b1);
        send(RK_CMD, 8'h10);
        chk("command", 16'h0010, {8'h00, cmd_o});
        send(RK_ADDR_HI, 8'h00);
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            a = {4'h3, (i == 0) ? 4'h0 : (i == 1) ? 4'hF : r[3:0]};
            w = r[31:16];
            send(RK_ADDR_LO, a);
            send(RK_DATA_LO, w[7:0]);
            send(RK_DATA_HI, w[15:8]);
            chk("command", 16'h0010, {8'h00, cmd_o});
            send(RK_PAGE_LATCH_STROBE, 8'h00);
            model[a] = w;
            q.push_back(a);
        end
        send(RK_WRITE, 8'h00);
        chk("prog_busy", 16'h0001, {15'h0000, busy_n >= 20});
        foreach (q[i]) begin
            rd(q[i]);
            chk("flash", model[q[i]], rd_data);
        end
        rd(8'h40);
        chk("flash", 16'hFFFF, rd_data);
        $display("test program done");
        erase(1'b0);
        conclude();
    end
endmodule // testbench

`default_nettype wire
